//--- tss_pkg.sv
// package: constants and register map for the slave trigger selection block
// Functional notes
// - filter codes 0110/0111 sample at base/4, needing 6 or 8 equal samples.
// - filter codes 1000/1001 sample at base/8, needing 6 or 8 equal samples.
// - codes 1010/1011/1100 sample at base/16, needing 5, 6, 8 samples.
// - codes 1101/1110/1111 sample at base/32, needing 5, 6, 8 samples.
// - filter field sits in bits 11:8, read/write, resets to zero.
// - sync delay bit set delays trigger input events one cycle; clear means none.
// - selector codes 000 to 011 route internal triggers 0 to 3.
// - codes 100..111 pick input1 edge, input1 filtered, input2 filtered, ext filtered.
package tss_pkg;
  localparam logic [11:0] TSS_CTRL_OFFSET   = 12'h008;
  localparam logic [11:0] TSS_STATUS_OFFSET = 12'h00c;
  localparam int          TSS_MODE_LSB      = 0;
  localparam int          TSS_SRC_LSB       = 4;
  localparam int          TSS_SYNC_BIT      = 7;
  localparam int          TSS_FILT_LSB      = 8;
  localparam logic [31:0] TSS_CTRL_RESET    = 32'h0000_0000;
  localparam int          TSS_DIV_W         = 5;
  localparam int          TSS_CNT_W         = 4;
endpackage : tss_pkg

//--- tss_trigger_select.sv
// module: slave trigger source selection with external trigger filter, apb slave
//
// Local design decisions: the address map and the APB interface to the registers.
module tss_trigger_select
  import tss_pkg::*;
(
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // trigger sources
  input  wire logic        internal_trigger_0,
  input  wire logic        internal_trigger_1,
  input  wire logic        internal_trigger_2,
  input  wire logic        internal_trigger_3,
  input  wire logic        input1_edge_detect,
  input  wire logic        input1_filtered,
  input  wire logic        input2_filtered,
  input  wire logic        ext_trigger_raw,
  // results
  output logic             ext_trigger_filtered,
  output logic             trigger_input
);
  logic [2:0]           slave_mode_field;
  logic [2:0]           trigger_source_select;
  logic                 sync_delay_enable;
  logic [3:0]           ext_trigger_filter;
  logic [TSS_DIV_W-1:0] div_cnt;
  logic [TSS_CNT_W-1:0] eq_cnt;
  logic [TSS_DIV_W-1:0] div_max;
  logic [TSS_CNT_W-1:0] need_n;
  logic                 sample_tick;
  logic                 sel_trig;
  logic                 sel_trig_q;

  wire access    = psel && penable;
  wire wr_ctrl   = access && pwrite && (paddr == TSS_CTRL_OFFSET);
  wire addr_ok   = (paddr == TSS_CTRL_OFFSET) || (paddr == TSS_STATUS_OFFSET);
  // zero wait states: the slave never stalls the bus
  assign pready  = 1'b1;
  assign pslverr = access && !addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slave_mode_field      <= TSS_CTRL_RESET[2:0];
      trigger_source_select <= TSS_CTRL_RESET[6:4];
      sync_delay_enable     <= TSS_CTRL_RESET[7];
      ext_trigger_filter    <= TSS_CTRL_RESET[11:8];
    end else if (wr_ctrl) begin
      slave_mode_field   <= pwdata[TSS_MODE_LSB +: 3];
      sync_delay_enable  <= pwdata[TSS_SYNC_BIT];
      ext_trigger_filter <= pwdata[TSS_FILT_LSB +: 4];
      // selector held while a slave mode is active
      if (slave_mode_field == 3'h0) begin
        trigger_source_select <= pwdata[TSS_SRC_LSB +: 3];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      if (paddr == TSS_CTRL_OFFSET) begin
        prdata <= {20'h00000, ext_trigger_filter, sync_delay_enable,
                   trigger_source_select, 1'b0, slave_mode_field};
      end else if (paddr == TSS_STATUS_OFFSET) begin
        prdata <= {30'h0, trigger_input, ext_trigger_filtered};
      end
    end
  end

  // lower codes: every clock, one sample
  // limitation: codes 0 to 5 act as no filter at all
  always_comb begin
    div_max = 5'h00;
    need_n  = 4'h1;
    unique case (ext_trigger_filter)
      4'h6: begin div_max = 5'h03; need_n = 4'h6; end
      4'h7: begin div_max = 5'h03; need_n = 4'h8; end
      4'h8: begin div_max = 5'h07; need_n = 4'h6; end
      4'h9: begin div_max = 5'h07; need_n = 4'h8; end
      4'ha: begin div_max = 5'h0f; need_n = 4'h5; end
      4'hb: begin div_max = 5'h0f; need_n = 4'h6; end
      4'hc: begin div_max = 5'h0f; need_n = 4'h8; end
      4'hd: begin div_max = 5'h1f; need_n = 4'h5; end
      4'he: begin div_max = 5'h1f; need_n = 4'h6; end
      4'hf: begin div_max = 5'h1f; need_n = 4'h8; end
      default: begin div_max = 5'h00; need_n = 4'h1; end
    endcase
  end

  // >= lets a newly smaller divider wrap at once, not count round to 31
  assign sample_tick = (div_cnt >= div_max);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
    end else if (sample_tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 5'h01;
    end
  end

  // output moves only after need_n equal samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eq_cnt               <= '0;
      ext_trigger_filtered <= 1'b0;
    end else if (sample_tick) begin
      if (ext_trigger_raw == ext_trigger_filtered) begin
        eq_cnt <= '0;
      end else if (eq_cnt + 4'h1 >= need_n) begin
        eq_cnt               <= '0;
        ext_trigger_filtered <= ext_trigger_raw;
      end else begin
        eq_cnt <= eq_cnt + 4'h1;
      end
    end
  end

  always_comb begin
    sel_trig = 1'b0;
    unique case (trigger_source_select)
      3'h0: sel_trig = internal_trigger_0;
      3'h1: sel_trig = internal_trigger_1;
      3'h2: sel_trig = internal_trigger_2;
      3'h3: sel_trig = internal_trigger_3;
      3'h4: sel_trig = input1_edge_detect;
      3'h5: sel_trig = input1_filtered;
      3'h6: sel_trig = input2_filtered;
      3'h7: sel_trig = ext_trigger_filtered;
    endcase
  end

  // one-cycle delay so trigger output sees the edge first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_trig_q    <= 1'b0;
      trigger_input <= 1'b0;
    end else begin
      sel_trig_q    <= sel_trig;
      trigger_input <= sync_delay_enable ? sel_trig_q : sel_trig;
    end
  end

  sync_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
    sync_delay_enable && $stable(sync_delay_enable) |-> trigger_input == $past(sel_trig, 2))
    else $error("delayed trigger mismatch");
  // guard: first edge after reset still shows the cleared flop
  no_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) && !sync_delay_enable && $past(!sync_delay_enable)
      |-> trigger_input == $past(sel_trig))
    else $error("undelayed trigger mismatch");

  sel_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    slave_mode_field != 3'h0 |=> $stable(trigger_source_select))
    else $error("selector changed with slave mode active");

  internal_trigger_0_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    trigger_source_select == 3'h0 |-> sel_trig == internal_trigger_0)
    else $error("internal trigger 0 route wrong");
  itr_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    trigger_source_select == 3'h2 |-> sel_trig == internal_trigger_2)
    else $error("internal trigger route wrong");
  in1_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    trigger_source_select == 3'h4 |-> sel_trig == input1_edge_detect)
    else $error("input1 edge route wrong");
  etr_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    trigger_source_select == 3'h7 |-> sel_trig == ext_trigger_filtered)
    else $error("external trigger route wrong");

  filt_change_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(ext_trigger_filtered) |-> $past(sample_tick) && $past(eq_cnt) + 4'h1 >= $past(need_n))
    else $error("filter changed early");
  filt_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !sample_tick |=> $stable(ext_trigger_filtered))
    else $error("filter moved between samples");
  eq_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    sample_tick && ext_trigger_raw == ext_trigger_filtered |=> eq_cnt == 4'h0)
    else $error("equal sample did not clear count");

  div4_a: assert property (@(posedge pclk) disable iff (!presetn)
    ext_trigger_filter == 4'h7 |-> div_max == 5'h03 && need_n == 4'h8)
    else $error("base/4 setting wrong");
  div8_a: assert property (@(posedge pclk) disable iff (!presetn)
    ext_trigger_filter[3:1] == 3'b100 && $stable(ext_trigger_filter)
      |-> div_cnt <= 5'h07 && need_n == (ext_trigger_filter[0] ? 4'h8 : 4'h6))
    else $error("base/8 setting wrong");
  div16_a: assert property (@(posedge pclk) disable iff (!presetn)
    ext_trigger_filter inside {4'ha, 4'hb, 4'hc} && $stable(ext_trigger_filter)
      |-> div_cnt <= 5'h0f && need_n == (ext_trigger_filter == 4'ha ? 4'h5 :
                                          ext_trigger_filter == 4'hb ? 4'h6 : 4'h8))
    else $error("base/16 setting wrong");
  div32_a: assert property (@(posedge pclk) disable iff (!presetn)
    ext_trigger_filter[3:2] == 2'b11 && ext_trigger_filter[1:0] != 2'b00 |-> div_max == 5'h1f)
    else $error("base/32 divider wrong");

  filt_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> ext_trigger_filter == $past(pwdata[11:8]))
    else $error("filter field not written");

  // main scenarios
  filt_rise_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(ext_trigger_filtered));
  delay_c: cover property (@(posedge pclk) disable iff (!presetn)
    sync_delay_enable && $rose(trigger_input));
  blocked_c: cover property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl && slave_mode_field != 3'h0);
  div32_c: cover property (@(posedge pclk) disable iff (!presetn)
    ext_trigger_filter == 4'hf && $rose(ext_trigger_filtered));
  unmapped_c: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule // tss_trigger_select

//--- tss_trig_model.sv
// far-side model: other timers driving the trigger source lines
module tss_trig_model (
  // control from the bench
  input  wire logic       pclk,
  input  wire logic [6:0] src_req,
  // trigger lines
  output logic      [6:0] lines
);
  timeunit 1ns;
  timeprecision 1ps;
  // registered like a real timer output, so levels move just after an edge
  always_ff @(posedge pclk) begin
    lines <= src_req;
  end
endmodule // tss_trig_model

//--- tss_trigger_select_test.sv
// testbench: selector routing, sync delay, filter timing, apb access
module tss_trigger_select_test
  import tss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, raw = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, flt, trg, se;
  logic [6:0]  src = '0, ln;
  int          err_total = 0, total_checks = 0, n, dv, nn;
  // {selector, source lines, expected trigger}
  logic [10:0] rows [8] = '{11'h003, 11'h105, 11'h209, 11'h311,
                            11'h421, 11'h541, 11'h681, 11'h67e};
  localparam logic [39:0] NTAB = 40'h6868568568;
  always #5 pclk = ~pclk;
  tss_trig_model u_tss_trig_model (.pclk, .src_req(src), .lines(ln));
  tss_trigger_select u_tss_trigger_select (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .internal_trigger_0(ln[0]),
    .internal_trigger_1(ln[1]), .internal_trigger_2(ln[2]), .internal_trigger_3(ln[3]),
    .input1_edge_detect(ln[4]), .input1_filtered(ln[5]), .input2_filtered(ln[6]),
    .ext_trigger_raw(raw), .ext_trigger_filtered(flt), .trigger_input(trg));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %0t: got %h exp %h", $time, s, e);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin err_total++; test_done; end
    rd = prdata;
    se = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // counts edges until the chosen output reaches v
  task automatic wt(input bit f, input logic v);
    n = 0;
    do begin @(posedge pclk); #1 n++; end while ((f ? flt : trg) !== v && n < 400);
    if (n >= 400) begin err_total++; test_done; end
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    apb(0, TSS_CTRL_OFFSET, 0);
    chk(rd, TSS_CTRL_RESET);
    foreach (rows[i]) begin
      apb(1, TSS_CTRL_OFFSET, {rows[i][10:8], 4'h0});
      src <= rows[i][7:1];
      repeat (3) @(posedge pclk);
      chk(trg, rows[i][0]);
      src <= 0;
      $display("route row %0d done", i);
    end
    for (int d = 0; d < 2; d++) begin
      apb(1, TSS_CTRL_OFFSET, d << TSS_SYNC_BIT);
      src <= 7'h01;
      wt(0, 1);
      chk(n, 2 + d);
      src <= 0;
      wt(0, 0);
    end
    $display("sync delay done");
    for (int c = 6; c < 16; c++) begin
      dv = c < 8 ? 4 : c < 10 ? 8 : c < 13 ? 16 : 32;
      nn = NTAB[(15 - c) * 4 +: 4];
      apb(1, TSS_CTRL_OFFSET, (7 << TSS_SRC_LSB) | (c << TSS_FILT_LSB));
      // too short a pulse: at most nn-2 samples see it
      raw <= 1;
      repeat (dv * (nn - 2)) @(posedge pclk);
      raw <= 0;
      repeat (dv) @(posedge pclk);
      chk(flt, 0);
      raw <= 1;
      wt(1, 1);
      chk(n > (nn - 1) * dv && n <= nn * dv + 3, 1);
      apb(0, TSS_STATUS_OFFSET, 0);
      chk(rd[1:0], 2'b11);
      raw <= 0;
      wt(1, 0);
      $display("filter code %0d done", c);
    end
    apb(1, TSS_CTRL_OFFSET, 32'h0000_0011);
    apb(1, TSS_CTRL_OFFSET, 32'h0000_0031);
    apb(0, TSS_CTRL_OFFSET, 0);
    chk(rd[6:4], 3'h1);
    apb(1, TSS_CTRL_OFFSET, 0);
    apb(1, TSS_CTRL_OFFSET, 32'h0000_0f00);
    apb(0, TSS_CTRL_OFFSET, 0);
    chk(rd[11:8], 4'hf);
    apb(0, 12'h010, 0);
    chk(se, 1);
    chk(rd, 0);
    $display("register access done");
    // mid-run reset with a live source and a nonzero filter field
    src <= 7'h01;
    wt(0, 1);
    @(posedge pclk);
    presetn <= 0;
    src <= 0;
    repeat (2) @(posedge pclk);
    chk(trg, 0);
    chk(flt, 0);
    presetn <= 1;
    apb(0, TSS_CTRL_OFFSET, 0);
    chk(rd, TSS_CTRL_RESET);
    $display("reset test done");
    test_done;
  end
endmodule // tss_trigger_select_test
